// ==== include/rtcis_defines.svh ====
`ifndef RTCIS_DEFINES_SVH
`define RTCIS_DEFINES_SVH

// Slave address and direction bit
`define RTCIS_SLAVE_ADDR  7'h68
`define RTCIS_DIR_WRITE   1'h0
`define RTCIS_DIR_READ    1'h1

// Byte framing
`define RTCIS_BYTE_BITS   4'h8
`define RTCIS_LAST_BIT    4'h7

// Reset values
`define RTCIS_PTR_RESET   8'h00
`define RTCIS_DATA_RESET  8'h00

// Bus clock limits and system clock
`define RTCIS_CLK_HZ      100000000
`define RTCIS_STD_SCL_HZ  100000
`define RTCIS_FAST_SCL_HZ 400000
// Samples per fastest bus clock period
`define RTCIS_FAST_SCL_CYCLES (`RTCIS_CLK_HZ / `RTCIS_FAST_SCL_HZ)

`endif

// ==== include/rtcis_pkg.sv ====
package rtcis_pkg;

  typedef enum logic [3:0]
  {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK
  } rtcis_state_t;

endpackage

// ==== include/rtcis_line_if.sv ====
`timescale 1ns/100ps

interface rtcis_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport cond
  (
    output scl_rise,
    output scl_fall,
    output start,
    output stop,
    output sda
  );

  modport fsm
  (
    input scl_rise,
    input scl_fall,
    input start,
    input stop,
    input sda
  );
endinterface

// ==== hdl/rtcis_bus_cond.sv ====
`timescale 1ns/100ps

module rtcis_bus_cond
(
  input  wire logic   clock_i,
  input  wire logic   sys_rst_i,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  rtcis_line_if.cond  line
);

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_prev;
  logic       sda_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Both lines share one delay so their relative order is kept
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      scl_prev <= 1'h1;
      sda_prev <= 1'h1;
    end
    else
    begin
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign line.scl_rise = scl_sync[1] & ~scl_prev;
  assign line.scl_fall = ~scl_sync[1] & scl_prev;
  assign line.start    = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1]; // [R19]
  assign line.stop     = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1]; // [R19]
  assign line.sda      = sda_sync[1];

endmodule

// ==== hdl/rtcis_byte_shift.sv ====
`timescale 1ns/100ps

`include "rtcis_defines.svh"

module rtcis_byte_shift
(
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clear_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_data_i,
  input  wire logic       shift_i,
  input  wire logic       shift_bit_i,
  input  wire logic       count_i,
  output logic      [7:0] data_o,
  output logic      [3:0] count_o
);

  ////////////////////////////////////////////////////////////////////////////
  // One register serves both directions, always MSB end first
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      data_o <= `RTCIS_DATA_RESET;
    else if (load_i)
      data_o <= load_data_i;
    else if (shift_i)
      data_o <= {data_o[6:0], shift_bit_i}; // [R8]
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || clear_i)
      count_o <= 4'h0;
    else if (count_i)
      count_o <= count_o + 4'h1;
  end

endmodule

// ==== hdl/rtcis_slave.sv ====
// Summary of operation
// R1 - Master frames each transfer with START, STOP
// R2 - Bytes of eight bits, ninth bit acknowledges
// R3 - Addressed receiver acknowledges every received byte
// R4 - Master gives extra clock for acknowledge
// R5 - Acknowledger holds SDA low through ack high
// R6 - Master reader NACKs only the final byte
// R7 - After NACK release SDA; read ends there
// R8 - All bytes shifted most significant bit first
// R9 - Repeated START ends transfer, begins new one
// R10 - Master alone drives SCL, START and STOP
// R11 - First byte after START is address byte
// R12 - Respond only to address 1101000 plus direction
// R13 - Acknowledge a matching address byte
// R14 - First write byte loads register pointer
// R15 - Write data bytes stored and acknowledged each
// R16 - Pointer increments after every data byte
// R17 - Read data starts at current pointer
// R18 - Without pointer write, read from stored pointer
// R19 - START is SDA fall, STOP rise, SCL high
// R20 - SDA changes only while SCL is low
// R21 - Works at 100kHz and 400kHz bus clocks
// R22 - Unmatched address: stay released until next START
`timescale 1ns/100ps

`include "rtcis_defines.svh"

module rtcis_slave
(
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i,
  output logic            busy_o
);

  rtcis_pkg::rtcis_state_t state;
  logic                    dir_read;
  logic                    ack_on;
  logic                    master_ack;
  logic [7:0]              ptr;
  logic [7:0]              shift_data;
  logic [3:0]              bit_count;
  logic                    rx_state;
  logic                    ack_state;
  logic                    byte_done;
  logic [7:0]              rx_byte;
  logic                    ack_end;
  logic                    load_tx;
  logic                    shift_en;
  logic                    count_en;
  logic                    clear_count;
  logic                    next_sda_oe;

  rtcis_line_if line ();

  ////////////////////////////////////////////////////////////////////////////
  // At 100 MHz even a 400 kHz bus gives hundreds of samples per bit,
  // so the two-stage delay stays far inside the low phase [R21]
  rtcis_bus_cond u_cond
  (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .line      (line.cond)
  );

  rtcis_byte_shift u_shift
  (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .clear_i     (clear_count),
    .load_i      (load_tx),
    .load_data_i (reg_rdata_i),
    .shift_i     (shift_en),
    .shift_bit_i (rx_state ? line.sda : 1'h1),
    .count_i     (count_en),
    .data_o      (shift_data),
    .count_o     (bit_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge-qualified controls
  assign rx_state  = (state == rtcis_pkg::ST_ADDR) || (state == rtcis_pkg::ST_PTR) ||
                     (state == rtcis_pkg::ST_WDATA);
  assign ack_state = (state == rtcis_pkg::ST_ADDR_ACK) || (state == rtcis_pkg::ST_PTR_ACK) ||
                     (state == rtcis_pkg::ST_WDATA_ACK);
  // Data sampled on SCL rise, eighth bit completes the byte [R2] [R20]
  assign byte_done = rx_state && line.scl_rise && (bit_count == `RTCIS_LAST_BIT);
  assign rx_byte   = {shift_data[6:0], line.sda};
  // Falling edge closing the ninth clock
  assign ack_end   = ack_state && line.scl_fall && ack_on;
  // Read data fetched at the pointer on each new byte [R17] [R18]
  assign load_tx   = line.scl_fall && !line.start && !line.stop &&
                     (((state == rtcis_pkg::ST_ADDR_ACK) && ack_on && dir_read) ||
                      ((state == rtcis_pkg::ST_RACK) && master_ack));
  // Transmit bits advance only on SCL fall [R20]
  assign shift_en  = (rx_state && line.scl_rise) ||
                     ((state == rtcis_pkg::ST_RDATA) && line.scl_fall &&
                      (bit_count != `RTCIS_BYTE_BITS));
  assign count_en  = line.scl_rise && (rx_state || (state == rtcis_pkg::ST_RDATA));
  assign clear_count = line.start || ack_end || load_tx;

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; START and STOP override every state
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      state <= rtcis_pkg::ST_IDLE;
    else if (line.start)
      state <= rtcis_pkg::ST_ADDR; // [R9] [R11]
    else if (line.stop)
      state <= rtcis_pkg::ST_IDLE;
    else
    begin
      unique case (state)
        rtcis_pkg::ST_IDLE:
          state <= rtcis_pkg::ST_IDLE; // [R22]
        rtcis_pkg::ST_ADDR:
          if (byte_done)
          begin
            if (rx_byte[7:1] == `RTCIS_SLAVE_ADDR) // [R12]
              state <= rtcis_pkg::ST_ADDR_ACK;
            else
              state <= rtcis_pkg::ST_IDLE; // [R22]
          end
        rtcis_pkg::ST_ADDR_ACK:
          if (ack_end)
            state <= dir_read ? rtcis_pkg::ST_RDATA : rtcis_pkg::ST_PTR;
        rtcis_pkg::ST_PTR:
          if (byte_done)
            state <= rtcis_pkg::ST_PTR_ACK;
        rtcis_pkg::ST_PTR_ACK:
          if (ack_end)
            state <= rtcis_pkg::ST_WDATA;
        rtcis_pkg::ST_WDATA:
          if (byte_done)
            state <= rtcis_pkg::ST_WDATA_ACK;
        rtcis_pkg::ST_WDATA_ACK:
          if (ack_end)
            state <= rtcis_pkg::ST_WDATA; // [R15]
        rtcis_pkg::ST_RDATA:
          if (line.scl_fall && (bit_count == `RTCIS_BYTE_BITS))
            state <= rtcis_pkg::ST_RACK;
        rtcis_pkg::ST_RACK:
          if (line.scl_rise && line.sda)
            state <= rtcis_pkg::ST_IDLE; // [R7]
          else if (load_tx)
            state <= rtcis_pkg::ST_RDATA;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      dir_read <= 1'h0;
    else if ((state == rtcis_pkg::ST_ADDR) && byte_done)
      dir_read <= (rx_byte[0] == `RTCIS_DIR_READ); // [R12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ack slot: on from the eighth fall to the ninth fall [R3] [R13]
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || line.start || line.stop)
      ack_on <= 1'h0;
    else if (ack_state && line.scl_fall)
      ack_on <= !ack_on; // [R5]
  end

  // Master acknowledge sampled during the ninth clock high
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || line.start || line.stop || load_tx)
      master_ack <= 1'h0;
    else if ((state == rtcis_pkg::ST_RACK) && line.scl_rise && !line.sda)
      master_ack <= 1'h1; // [R6]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer kept across transfers; only a pointer byte reloads it
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      ptr <= `RTCIS_PTR_RESET;
    else if ((state == rtcis_pkg::ST_PTR) && byte_done)
      ptr <= rx_byte; // [R14]
    else if (reg_wr_o || load_tx)
      ptr <= ptr + 8'h01; // [R16]
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      reg_wdata_o <= `RTCIS_DATA_RESET;
    else if ((state == rtcis_pkg::ST_WDATA) && byte_done)
      reg_wdata_o <= rx_byte; // [R15]
  end

  // Write strobe one cycle after the byte, pointer steps the cycle after
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      reg_wr_o <= 1'h0;
    else
      reg_wr_o <= (state == rtcis_pkg::ST_WDATA) && byte_done;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      reg_rd_o <= 1'h0;
    else
      reg_rd_o <= load_tx;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open drain: only ever pull low; SCL is never driven [R10]
  always_comb
  begin
    next_sda_oe = 1'h0;
    if (line.start || line.stop)
      next_sda_oe = 1'h0;
    else if (ack_state)
      next_sda_oe = ack_on; // [R3] [R5]
    else if (state == rtcis_pkg::ST_RDATA)
      // Last bit held until the eighth fall; release then happens in RACK,
      // so SDA never moves while SCL is high [R8] [R20]
      next_sda_oe = !shift_data[7];
  end

  // Registered drive keeps the enable free of combinational glitches
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      sda_oe_o <= 1'h0;
    else
      sda_oe_o <= next_sda_oe; // [R20] [R7]
  end

  assign sda_o      = 1'h0;
  assign reg_addr_o = ptr;
  assign busy_o     = (state != rtcis_pkg::ST_IDLE);

endmodule

// ==== sim/rtcis_slave_sva.sv ====
`timescale 1ns/100ps

module rtcis_slave_sva
(
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       sda_o,
  input  wire logic       sda_oe_o,
  input  wire logic [7:0] reg_addr_o,
  input  wire logic       reg_wr_o,
  input  wire logic       reg_rd_o,
  input  wire logic       busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_sda_zero: assert property (sda_o == 1'b0)
    else $error("sda value not low");
  a_wr_pulse: assert property (reg_wr_o |-> busy_o ##1 !reg_wr_o)
    else $error("write strobe too long");
  a_wr_incr: assert property (reg_wr_o |=> reg_addr_o == $past(reg_addr_o) + 8'h01)
    else $error("pointer not advanced on write");
  a_rd_incr: assert property (reg_rd_o |-> reg_addr_o == $past(reg_addr_o) + 8'h01)
    else $error("pointer not advanced on read");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda moved while scl high");
  a_idle_quiet: assert property (!busy_o |-> !sda_oe_o)
    else $error("sda driven while idle");
  a_start_busy: assert property ($fell(sda_i) && scl_i |-> ##[1:8] busy_o)
    else $error("start not seen");
  a_stop_idle: assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:8] !busy_o)
    else $error("stop not seen");
  a_wr_ack: assert property (reg_wr_o |-> ##[1:12] sda_oe_o)
    else $error("written byte not acknowledged");
  c_write: cover property (reg_wr_o);
  c_read: cover property (reg_rd_o);
  c_done: cover property ($fell(busy_o));
endmodule

bind rtcis_slave rtcis_slave_sva u_sva (.clock_i, .sys_rst_i, .scl_i, .sda_i, .sda_o,
  .sda_oe_o, .reg_addr_o, .reg_wr_o, .reg_rd_o, .busy_o);

// ==== sim/rtcis_master_model.sv ====
`timescale 1ns/100ps

module rtcis_master_model
(
  input  wire logic clock_i,
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  ////////////////////////////////////////
  // Quarter bit of 4 cycles, 160 ns bus clock
  task automatic q();
    repeat (4) @(posedge clock_i);
    #1;
  endtask
  // Works from idle or from scl low, so also a repeated start
  task automatic start_c();
    sda_oe_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_oe_o = 1'b1;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic stop_c();
    sda_oe_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_oe_o = 1'b0;
    q();
  endtask
  // Data set in low phase, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_oe_o = ~b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask
  // Ninth bit: ack_i 0 acknowledges, 1 releases
  task automatic byte_x(input logic [7:0] d, input logic ack_i,
                        output logic [7:0] r, output logic ack_o);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], b);
      r[i] = b;
    end
    bit_x(ack_i, ack_o);
  endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench;
  logic       clock_i;
  logic       sys_rst_i;
  logic       m_scl;
  logic       m_oe;
  logic       d_sda;
  logic       d_oe;
  wire  logic sda_pin;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       busy;
  logic [7:0] mem [256];
  logic [7:0] q;
  logic       ak;
  int         error_cnt;
  int         compares;
  // Open drain with pull-up
  assign sda_pin = ~(m_oe | (d_oe & ~d_sda));
  rtcis_slave u_dut (.clock_i, .sys_rst_i, .scl_i(m_scl), .sda_i(sda_pin), .sda_o(d_sda),
    .sda_oe_o(d_oe), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(),
    .reg_rdata_i(mem[addr]), .busy_o(busy));
  rtcis_master_model u_mst (.clock_i, .scl_o(m_scl), .sda_oe_o(m_oe), .sda_i(sda_pin));
  always @(posedge clock_i)
    if (wr) mem[addr] <= wdata;
  ////////////////////////////////////////
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic [7:0] d, input logic e);
    u_mst.byte_x(d, 1'b1, q, ak);
    `CHK(ak, e)
  endtask
  task automatic rb(input logic [7:0] e, input logic nack);
    u_mst.byte_x(8'hFF, nack, q, ak);
    `CHK(q, e)
  endtask
  task automatic t_write();
    u_mst.start_c();
    wb(8'hD0, 1'b0);
    wb(8'h3E, 1'b0);
    wb(8'hA5, 1'b0);
    wb(8'h5A, 1'b0);
    u_mst.stop_c();
    `CHK(mem[8'h3E], 8'hA5)
    `CHK(mem[8'h3F], 8'h5A)
    `CHK(addr, 8'h40)
  endtask
  task automatic t_read_restart();
    u_mst.start_c();
    wb(8'hD0, 1'b0);
    wb(8'h10, 1'b0);
    u_mst.start_c();
    wb(8'hD1, 1'b0);
    for (int i = 0; i < 3; i++)
      rb(8'(8'h10 + i) ^ 8'h5C, i == 2);
    // Give the release time to cross the synchroniser
    repeat (6) @(posedge clock_i);
    `CHK(sda_pin, 1'b1)
    u_mst.stop_c();
  endtask
  task automatic t_read_stored();
    u_mst.start_c();
    wb(8'hD1, 1'b0);
    rb(8'h13 ^ 8'h5C, 1'b1);
    u_mst.stop_c();
    `CHK(busy, 1'b0)
  endtask
  task automatic t_bad_addr();
    for (int i = 0; i < 2; i++)
    begin
      u_mst.start_c();
      wb(i ? 8'h50 : 8'hD2, 1'b1);
      wb(8'h3E, 1'b1);
      wb(8'h00, 1'b1);
      `CHK(busy, 1'b0)
      u_mst.stop_c();
    end
    `CHK(mem[8'h3E], 8'hA5)
  endtask
  ////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial
  begin
    #500000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    sys_rst_i = 1'b1;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5C;
    repeat (6) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (4) @(posedge clock_i);
    t_write();
    t_read_restart();
    t_read_stored();
    t_bad_addr();
    wrap_up();
  end
endmodule
